/* sicmd_pkg.sv */
// Package with register map, field layout and command codes
package sicmd_pkg;
    // ==========================================================
    // Register map (word byte addresses)
    localparam logic [3:0]  SICMD_ADDR_CMD     = 4'h0;
    localparam logic [3:0]  SICMD_ADDR_ROW     = 4'h4;
    localparam logic [3:0]  SICMD_ADDR_STATUS  = 4'h8;
    // ==========================================================
    // Field positions of the command register
    localparam int          SICMD_BCAST_BIT    = 10;
    localparam int          SICMD_MODE_HI      = 9;
    localparam int          SICMD_MODE_LO      = 8;
    localparam int          SICMD_GO_BIT       = 7;
    localparam int          SICMD_CHAN_BIT     = 6;
    localparam int          SICMD_SIDE_HI      = 5;
    localparam int          SICMD_SIDE_LO      = 3;
    localparam int          SICMD_OP_HI        = 2;
    localparam int          SICMD_OP_LO        = 0;
    localparam int          SICMD_PRE_ALL_BIT  = 10;  // Bit of the row value
    // ==========================================================
    // Reset values, and the strobe delay default loaded at calibration end
    localparam logic [15:0] SICMD_CMD_RESET    = 16'h0000;
    localparam logic [15:0] SICMD_ROW_RESET    = 16'h0000;
    localparam logic [3:0]  SICMD_DQS_DEFAULT  = 4'h2;
    // ==========================================================
    // Opcodes
    localparam logic [2:0]  SICMD_OP_NOP       = 3'h0;
    localparam logic [2:0]  SICMD_OP_CAL       = 3'h1;
    localparam logic [2:0]  SICMD_OP_PRE       = 3'h2;
    localparam logic [2:0]  SICMD_OP_MRS       = 3'h3;
    localparam logic [2:0]  SICMD_OP_REF       = 3'h5;
    // SDRAM command encodings {ras_n, cas_n, we_n}
    localparam logic [2:0]  SICMD_PIN_NOP      = 3'h7;
    localparam logic [2:0]  SICMD_PIN_PRE      = 3'h2;
    localparam logic [2:0]  SICMD_PIN_MRS      = 3'h0;
    localparam logic [2:0]  SICMD_PIN_REF      = 3'h1;
    // ==========================================================
    // Timing
    localparam int          SICMD_CLK_MHZ      = 250;
    localparam int          SICMD_CAL_NS       = 200;
    localparam int          SICMD_CAL_CYC      =
        (SICMD_CAL_NS * SICMD_CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  SICMD_CAL_CNT      = 8'(SICMD_CAL_CYC);
endpackage : sicmd_pkg

/* sicmd_issuer.sv */
// Software-triggered SDRAM initialisation command issuer
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: Broadcast set sends the command to all rows on both channels.
// RL2: Broadcast clear sends only to selected channel and side.
// RL3: Mode register set drives mode_function_bits onto BA[1:0].
// RL4: Mode register set drives A[14:0] from the row value register.
// RL5: Writing go starts the command; go clears once it finishes.
// RL6: Software waits for go to read zero before rewriting.
// RL7: Software programs the opcode, then sets go.
// RL8: channel_select one picks channel 1, zero picks channel 0.
// RL9: side_select value 0 to 7 picks chip select 0 to 7.
// RL10: Opcode 000 issues a no-operation to the selected side.
// RL11: Opcode 001 calibrates both channels, strobe delay to default.
// RL12: Software never calibrates during self-refresh.
// RL13: Opcode 010 precharges; bank bits and A10 pick single or all.
// RL14: Opcode 011 issues mode register set from both registers.
// RL15: Opcode 101 auto refreshes the selected side, ignoring broadcast.
// RL16: Reserved opcodes drive no command and still clear go.
module sicmd_issuer
    import sicmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [7:0]  sd0_cs_n,
    output logic      [7:0]  sd1_cs_n,
    output logic             sd_ras_n,
    output logic             sd_cas_n,
    output logic             sd_we_n,
    output logic      [1:0]  sd_ba,
    output logic      [14:0] sd_addr,
    output logic      [3:0]  dqs_delay,
    output logic      [1:0]  cal_active
);
    // ==========================================================
    // State machine
    typedef enum logic [3:0] {
        SICMD_IDLE  = 4'b0001,
        SICMD_ISSUE = 4'b0010,
        SICMD_CAL   = 4'b0100,
        SICMD_DONE  = 4'b1000
    } sicmd_state_e;

    sicmd_state_e state_reg;
    sicmd_state_e state_next;
    logic [15:0]  cmd_reg;
    logic [15:0]  row_reg;
    logic [7:0]   cal_cnt_reg;
    logic         ack_reg;

    // ==========================================================
    // Bus decode
    wire         req       = (avs_read | avs_write) & ~ack_reg;
    wire         hit_cmd   = avs_address == SICMD_ADDR_CMD;
    wire         hit_row   = avs_address == SICMD_ADDR_ROW;
    wire         hit_stat  = avs_address == SICMD_ADDR_STATUS;
    wire         wr_lo     = req & avs_write & avs_byteenable[0];
    wire         wr_hi     = req & avs_write & avs_byteenable[1];
    wire         wr_cmd    = hit_cmd & (wr_lo | wr_hi);
    wire [15:0]  wmask     = {{8{wr_hi}}, {8{wr_lo}}};
    wire [15:0]  cmd_wr    = (cmd_reg & ~wmask)
                           | (avs_writedata[15:0] & wmask);
    wire         go        = cmd_reg[SICMD_GO_BIT];
    wire         bcast     = cmd_reg[SICMD_BCAST_BIT];
    wire         chan      = cmd_reg[SICMD_CHAN_BIT];
    wire [2:0]   side      = cmd_reg[SICMD_SIDE_HI:SICMD_SIDE_LO];
    wire [2:0]   opcode    = cmd_reg[SICMD_OP_HI:SICMD_OP_LO];
    wire [31:0]  rd_mux    = hit_cmd  ? {16'h0000, cmd_reg}
                           : hit_row  ? {16'h0000, row_reg}
                           : hit_stat ? {27'h0000000, state_reg, go}
                           : 32'h00000000;

    // ==========================================================
    // Target chip selects (active high, inverted onto the sd0_cs_n and sd1_cs_n pins)
    wire [7:0]   side_oh   = 8'h01 << side;                       // RL9
    wire         all_rows  = bcast & (opcode != SICMD_OP_REF);    // RL15
    wire [7:0]   cs0_sel   = all_rows ? 8'hFF                     // RL1
                           : (~chan ? side_oh : 8'h00);           // RL8
    wire [7:0]   cs1_sel   = all_rows ? 8'hFF
                           : (chan ? side_oh : 8'h00);            // RL2
    wire         op_valid  = opcode == SICMD_OP_NOP
                           | opcode == SICMD_OP_PRE
                           | opcode == SICMD_OP_MRS
                           | opcode == SICMD_OP_REF;
    wire [2:0]   pins      = opcode == SICMD_OP_PRE ? SICMD_PIN_PRE  // RL13
                           : opcode == SICMD_OP_MRS ? SICMD_PIN_MRS  // RL14
                           : opcode == SICMD_OP_REF ? SICMD_PIN_REF  // RL15
                           : SICMD_PIN_NOP;                          // RL10

    // ==========================================================
    // Next state
    always_comb begin
        case (state_reg)
            SICMD_IDLE: begin
                if (go && opcode == SICMD_OP_CAL) begin
                    state_next = SICMD_CAL;                       // RL11
                end else if (go) begin
                    state_next = SICMD_ISSUE;                     // RL5
                end else begin
                    state_next = SICMD_IDLE;
                end
            end
            SICMD_ISSUE: state_next = SICMD_DONE;
            SICMD_CAL: begin
                if (cal_cnt_reg == 8'h01) begin
                    state_next = SICMD_DONE;
                end else begin
                    state_next = SICMD_CAL;
                end
            end
            SICMD_DONE:  state_next = SICMD_IDLE;
            default:     state_next = SICMD_IDLE;
        endcase
    end

    // ==========================================================
    // Bus handshake: one wait cycle, then answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg         <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            ack_reg         <= req;
            avs_waitrequest <= ~req;  // Low for one cycle per access
            if (req) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Registers; go cleared at command completion (RL5, RL16)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= SICMD_CMD_RESET;
            row_reg <= SICMD_ROW_RESET;
        end else begin
            if (wr_cmd) begin
                cmd_reg <= cmd_wr;
            end else if (state_reg == SICMD_DONE) begin
                cmd_reg[SICMD_GO_BIT] <= 1'b0;                    // RL5
            end
            if (hit_row & wr_lo) begin
                row_reg[7:0] <= avs_writedata[7:0];
            end
            if (hit_row & wr_hi) begin
                row_reg[15:8] <= avs_writedata[15:8];
            end
        end
    end

    // ==========================================================
    // State, calibration timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= SICMD_IDLE;
            cal_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == SICMD_IDLE) begin
                cal_cnt_reg <= SICMD_CAL_CNT;
            end else if (state_reg == SICMD_CAL) begin
                cal_cnt_reg <= cal_cnt_reg - 8'h01;
            end
        end
    end

    // ==========================================================
    // SDRAM pins: command held one cycle in ISSUE
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sd0_cs_n   <= 8'hFF;
            sd1_cs_n   <= 8'hFF;
            {sd_ras_n, sd_cas_n, sd_we_n} <= SICMD_PIN_NOP;
            sd_ba      <= 2'h0;
            sd_addr    <= 15'h0000;
            dqs_delay  <= 4'h0;
            cal_active <= 2'h0;
        end else begin
            if (state_next == SICMD_ISSUE && op_valid) begin      // RL16
                sd0_cs_n <= ~cs0_sel;
                sd1_cs_n <= ~cs1_sel;
                {sd_ras_n, sd_cas_n, sd_we_n} <= pins;
                sd_ba    <= cmd_reg[SICMD_MODE_HI:SICMD_MODE_LO]; // RL3
                sd_addr  <= row_reg[14:0];                        // RL4
            end else begin
                sd0_cs_n <= 8'hFF;
                sd1_cs_n <= 8'hFF;
                {sd_ras_n, sd_cas_n, sd_we_n} <= SICMD_PIN_NOP;
            end
            cal_active <= {2{state_next == SICMD_CAL}};           // RL11
            if (state_reg == SICMD_CAL && state_next == SICMD_DONE) begin
                dqs_delay <= SICMD_DQS_DEFAULT;                   // RL11
            end
        end
    end

    // ==========================================================
    // Assertions
    logic [7:0]   cal_len_reg;

    // Helper count of the cycles spent in calibration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_len_reg <= 8'h00;
        end else if (state_reg == SICMD_CAL) begin
            cal_len_reg <= cal_len_reg + 8'h01;
        end else begin
            cal_len_reg <= 8'h00;
        end
    end

    // Go clears once the command is done
    a_go_clears_done: assert property ( // RL5
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_DONE && !wr_cmd)
        |=> !go)
        else $error("go not cleared after completion");

    // A set go leaves idle on the next edge
    a_go_starts_cmd: assert property ( // RL5
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_IDLE && go)
        |=> state_reg != SICMD_IDLE)
        else $error("go did not start a command");

    // Mode set carries the mode function bits on the bank pins
    a_mrs_ba_drive: assert property ( // RL3
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_MRS)
        |=> sd_ba == $past(cmd_reg[9:8]) && !sd_we_n)
        else $error("mode set bank bits wrong");

    // Mode set carries the row value on the address pins
    a_mrs_addr_drive: assert property ( // RL4
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_MRS)
        |=> sd_addr == $past(row_reg[14:0]))
        else $error("mode set address wrong");

    // Broadcast selects every row of both channels, except for auto refresh
    a_bcast_all_rows: assert property ( // RL1
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && bcast && opcode != SICMD_OP_REF
         && op_valid)
        |=> sd0_cs_n == 8'h00 && sd1_cs_n == 8'h00)
        else $error("broadcast missed rows");

    // Without broadcast exactly one row is selected
    a_sel_one_row: assert property ( // RL2
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && (!bcast || opcode == SICMD_OP_REF)
         && op_valid)
        |=> $countones(~{sd1_cs_n, sd0_cs_n}) == 1)
        else $error("single target not unique");

    // Channel picks the chip select bank, side picks the line in it
    a_chan_side_map: assert property ( // RL8 RL9
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && (!bcast || opcode == SICMD_OP_REF)
         && op_valid)
        |=> ~{sd1_cs_n, sd0_cs_n} == 16'h0001 << $past({chan, side}))
        else $error("channel or side mapping wrong");

    // No-operation drives idle pins to a selected row
    a_nop_pins: assert property ( // RL10
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_NOP)
        |=> {sd_ras_n, sd_cas_n, sd_we_n} == SICMD_PIN_NOP
            && (sd0_cs_n & sd1_cs_n) != 8'hFF)
        else $error("nop not issued");

    // Precharge command encoding
    a_pre_pins: assert property ( // RL13
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_PRE)
        |=> {sd_ras_n, sd_cas_n, sd_we_n} == SICMD_PIN_PRE)
        else $error("precharge not issued");

    // Auto refresh command encoding
    a_ref_pins: assert property ( // RL15
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_REF)
        |=> {sd_ras_n, sd_cas_n, sd_we_n} == SICMD_PIN_REF)
        else $error("refresh not issued");

    // Auto refresh reaches one row even with broadcast set
    a_ref_skips_bcast: assert property ( // RL15
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_REF && bcast)
        |=> $countones(~{sd1_cs_n, sd0_cs_n}) == 1)
        else $error("refresh went to several rows");

    // Mode register set command encoding
    a_mrs_pins: assert property ( // RL14
        @(posedge clk) disable iff (!rst_n)
        (state_next == SICMD_ISSUE && opcode == SICMD_OP_MRS)
        |=> {sd_ras_n, sd_cas_n, sd_we_n} == SICMD_PIN_MRS)
        else $error("mode set not issued");

    // Calibration end loads the default strobe delay
    a_cal_delay_set: assert property ( // RL11
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_CAL && state_next == SICMD_DONE)
        |=> dqs_delay == SICMD_DQS_DEFAULT && cal_active == 2'h0)
        else $error("calibration end wrong");

    // Both channels calibrate together, with no command sent
    a_cal_both_chan: assert property ( // RL11
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_CAL)
        |-> cal_active == 2'h3 && (sd0_cs_n & sd1_cs_n) == 8'hFF)
        else $error("calibration not on both channels");

    // Calibration lasts its full count of cycles
    a_cal_length: assert property ( // RL11
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_CAL && state_next == SICMD_DONE)
        |-> cal_len_reg == SICMD_CAL_CNT - 8'h01)
        else $error("calibration length wrong");

    // Reserved opcodes leave every chip select high
    a_rsvd_silent: assert property ( // RL16
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_IDLE && go && !op_valid
         && opcode != SICMD_OP_CAL)
        |=> (sd0_cs_n & sd1_cs_n) == 8'hFF
            ##1 (sd0_cs_n & sd1_cs_n) == 8'hFF)
        else $error("reserved opcode drove a command");

    // Reserved opcodes still clear go
    a_rsvd_go_clears: assert property ( // RL16
        @(posedge clk) disable iff (!rst_n)
        (state_reg == SICMD_IDLE && go && !op_valid
         && opcode != SICMD_OP_CAL)
        |=> ##2 !go)
        else $error("reserved opcode left go set");

    // Chip selects go low only while a command is issued
    a_cs_only_issue: assert property ( // RL5
        @(posedge clk) disable iff (!rst_n)
        ((sd0_cs_n & sd1_cs_n) != 8'hFF)
        |-> state_reg == SICMD_ISSUE)
        else $error("command outside issue state");

    // A taken access is answered on the next cycle
    a_wait_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        ((avs_read || avs_write) && avs_waitrequest)
        |=> !avs_waitrequest)
        else $error("access not answered in one cycle");

    // The answer stands for one cycle only
    a_wait_stands_one: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!avs_waitrequest)
        |=> avs_waitrequest)
        else $error("answer held too long");
endmodule : sicmd_issuer
`default_nettype wire

/* sicmd_dimm_model.sv */
// Behavioural model of the DIMM rows on both branch channels
`timescale 1ns/1ps
`default_nettype none
module sicmd_dimm_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  cs0_n,
    input  wire logic [7:0]  cs1_n,
    input  wire logic [2:0]  pins,
    input  wire logic [1:0]  ba,
    input  wire logic [14:0] addr,
    input  wire logic [1:0]  cal,
    output logic      [7:0]  cnt,
    output logic      [7:0]  l_cs0,
    output logic      [7:0]  l_cs1,
    output logic      [2:0]  l_pin,
    output logic      [1:0]  l_ba,
    output logic      [14:0] l_addr,
    output logic      [1:0]  cal_seen
);
    // ==========================================================
    // Command capture
    // A row only takes a command while its chip select is low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= 8'h00;
            l_cs0    <= 8'hFF;
            l_cs1    <= 8'hFF;
            l_pin    <= 3'h7;
            l_ba     <= 2'h0;
            l_addr   <= 15'h0000;
            cal_seen <= 2'h0;
        end else begin
            cal_seen <= cal_seen | cal;
            if ((&cs0_n & &cs1_n) == 1'b0) begin
                cnt    <= cnt + 8'h01;
                l_cs0  <= cs0_n;
                l_cs1  <= cs1_n;
                l_pin  <= pins;
                l_ba   <= ba;
                l_addr <= addr;
            end
        end
    end
endmodule : sicmd_dimm_model
`default_nettype wire

/* sicmd_issuer_tb_top.sv */
// Self-checking testbench of the init command issuer
`timescale 1ns/1ps
`default_nettype none
module sicmd_issuer_tb_top;
    import sicmd_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] adr = 4'h0, be = 4'hF;
    logic [31:0] wd = 32'h0, rdat;
    logic wait_r, ras, cas, we;
    logic [7:0] cs0, cs1, cnt, l0, l1;
    logic [1:0] ba, lba, cal, cals;
    logic [14:0] sa, la;
    logic [2:0] lp;
    logic [3:0] dqs;
    int err_total = 0, compares = 0;
    always #2 clk = ~clk;
    sicmd_issuer sicmd_issuer_inst (.clk(clk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .sd0_cs_n(cs0), .sd1_cs_n(cs1),
        .sd_ras_n(ras), .sd_cas_n(cas), .sd_we_n(we), .sd_ba(ba),
        .sd_addr(sa), .dqs_delay(dqs), .cal_active(cal));
    sicmd_dimm_model sicmd_dimm_model_inst (.clk(clk), .rst_n(rst_n),
        .cs0_n(cs0), .cs1_n(cs1), .pins({ras, cas, we}), .ba(ba),
        .addr(sa), .cal(cal), .cnt(cnt), .l_cs0(l0), .l_cs1(l1),
        .l_pin(lp), .l_ba(lba), .l_addr(la), .cal_seen(cals));
    // ==========================================================
    // Checking and closing
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        compares++;
        if (seen !== e) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", nm, e, seen);
        end
    endtask : chk
    task close_out;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    // ==========================================================
    // Avalon access: hold request until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wait_r !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    // Program opcode, then set go, wait for go to clear, check pins
    task do_cmd(input logic b, input logic [1:0] m, input logic c,
                input logic [2:0] s, input logic [2:0] op, input logic en,
                input logic [2:0] pin, input logic [7:0] e0, e1);
        logic [15:0] w;
        logic [31:0] q;
        logic [7:0] n0;
        int k;
        w = {5'h00, b, m, 1'b0, c, s, op};
        n0 = cnt;
        bus(1'b1, SICMD_ADDR_CMD, {16'h0000, w}, q);
        w[SICMD_GO_BIT] = 1'b1;
        bus(1'b1, SICMD_ADDR_CMD, {16'h0000, w}, q);
        k = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && k < 100) begin
            bus(1'b0, SICMD_ADDR_STATUS, 32'h0, q);
            k++;
        end
        chk("go clear", q & 32'h1, 32'h0);
        bus(1'b0, SICMD_ADDR_CMD, 32'h0, q);
        chk("cmd back", q, {16'h0000, w & 16'hFF7F});
        chk("cmd count", {24'h0, cnt}, {24'h0, n0 + {7'h00, en}});
        if (en) begin
            chk("pins", {29'h0, lp}, {29'h0, pin});
            chk("cs0", {24'h0, l0}, {24'h0, e0});
            chk("cs1", {24'h0, l1}, {24'h0, e1});
            if (op == SICMD_OP_PRE || op == SICMD_OP_MRS)
                chk("ba", {30'h0, lba}, {30'h0, m});
            if (op == SICMD_OP_MRS)
                chk("addr", {17'h0, la}, 32'h4C31);
            if (op == SICMD_OP_PRE)
                chk("pre all", {31'h0, la[SICMD_PRE_ALL_BIT]}, 32'h1);
        end
    endtask : do_cmd
    // ==========================================================
    // Test sequence
    initial begin : main
        logic [31:0] q;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk("dqs rst", {28'h0, dqs}, 32'h0);
        bus(1'b0, SICMD_ADDR_CMD, 32'h0, q);
        chk("cmd rst", q, {16'h0000, SICMD_CMD_RESET});
        bus(1'b0, SICMD_ADDR_ROW, 32'h0, q);
        chk("row rst", q, {16'h0000, SICMD_ROW_RESET});
        bus(1'b1, 4'hC, 32'h1234, q);
        bus(1'b0, 4'hC, 32'h0, q);
        chk("unmapped", q, 32'h0);
        bus(1'b1, SICMD_ADDR_ROW, 32'h4C31, q);
        bus(1'b0, SICMD_ADDR_ROW, 32'h0, q);
        chk("row back", q, 32'h4C31);
        // Every side on alternating channels
        for (int s = 0; s < 8; s++) begin
            if (s[0]) do_cmd(1'b0, 2'h0, 1'b1, 3'(s), SICMD_OP_NOP, 1'b1,
                SICMD_PIN_NOP, 8'hFF, ~(8'h01 << s));
            else do_cmd(1'b0, 2'h0, 1'b0, 3'(s), SICMD_OP_NOP, 1'b1,
                SICMD_PIN_NOP, ~(8'h01 << s), 8'hFF);
        end
        do_cmd(1'b1, 2'h1, 1'b0, 3'h2, SICMD_OP_PRE, 1'b1,
            SICMD_PIN_PRE, 8'h00, 8'h00);
        do_cmd(1'b0, 2'h2, 1'b1, 3'h4, SICMD_OP_PRE, 1'b1,
            SICMD_PIN_PRE, 8'hFF, 8'hEF);
        do_cmd(1'b0, 2'h2, 1'b0, 3'h0, SICMD_OP_MRS, 1'b1,
            SICMD_PIN_MRS, 8'hFE, 8'hFF);
        do_cmd(1'b1, 2'h3, 1'b0, 3'h1, SICMD_OP_MRS, 1'b1,
            SICMD_PIN_MRS, 8'h00, 8'h00);
        do_cmd(1'b1, 2'h0, 1'b1, 3'h7, SICMD_OP_REF, 1'b1,
            SICMD_PIN_REF, 8'hFF, 8'h7F);
        do_cmd(1'b1, 2'h0, 1'b1, 3'h3, 3'h4, 1'b0, 3'h0, 8'h0, 8'h0);
        do_cmd(1'b0, 2'h1, 1'b0, 3'h5, 3'h6, 1'b0, 3'h0, 8'h0, 8'h0);
        do_cmd(1'b0, 2'h3, 1'b1, 3'h6, 3'h7, 1'b0, 3'h0, 8'h0, 8'h0);
        // Calibration, memory not in self-refresh here
        do_cmd(1'b0, 2'h0, 1'b0, 3'h0, SICMD_OP_CAL, 1'b0,
            3'h0, 8'h0, 8'h0);
        chk("cal both", {30'h0, cals}, 32'h3);
        chk("dqs cal", {28'h0, dqs}, {28'h0, SICMD_DQS_DEFAULT});
        // Upper byte lane alone, then a reset in mid-run
        be <= 4'h2;
        bus(1'b1, SICMD_ADDR_ROW, 32'h00007F00, q);
        be <= 4'hF;
        bus(1'b0, SICMD_ADDR_ROW, 32'h0, q);
        chk("row lane", q, 32'h7F31);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk("dqs mid rst", {28'h0, dqs}, 32'h0);
        bus(1'b0, SICMD_ADDR_ROW, 32'h0, q);
        chk("row mid rst", q, {16'h0000, SICMD_ROW_RESET});
        close_out();
    end
    // Watchdog
    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule : sicmd_issuer_tb_top
`default_nettype wire
